// ==== rtl/prsc_defs.svh ====
`ifndef PRSC_DEFS_SVH
`define PRSC_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define PRSC_OFS_MULT     8'h00
`define PRSC_OFS_REG      8'h04
`define PRSC_OFS_SLEEP    8'h08
`define PRSC_OFS_CFG      8'h0C
`define PRSC_OFS_STAT     8'h10
// ****************************************
// field positions
// ****************************************
`define PRSC_MULT_LOCK    0
`define PRSC_MULT_EN     1
`define PRSC_MULT_DIV_LO  2
`define PRSC_MULT_DIV_HI  4
`define PRSC_SLP_EN      0
`define PRSC_SLP_MODE_LO  1
`define PRSC_SLP_MODE_HI  3
`define PRSC_CFG_CMPDIS   0
`define PRSC_CFG_XTAL     1
`define PRSC_CFG_MSYS     2
// ****************************************
// mode codes
// ****************************************
`define PRSC_MODE_IDLE    3'h0
`define PRSC_MODE_PDOWN   3'h2
`define PRSC_MODE_PSAVE   3'h3
`define PRSC_MODE_STBY    3'h6
`define PRSC_MODE_XSTBY   3'h7
// ****************************************
// timing
// ****************************************
`define PRSC_CLK_NS        10
`define PRSC_LOCK_US       1000
`define PRSC_LOCK_CYC      ((`PRSC_LOCK_US * 1000) / `PRSC_CLK_NS)
`define PRSC_HALT_CYC      4
`define PRSC_STBY_CYC      6
`define PRSC_CNT_W         20
`define PRSC_RESET_DATA    32'h0000_0000
`endif

// ==== rtl/prsc_pkg.sv ====
package prsc_pkg;
  // sleep sequencer states, gray along the run-sleep-wake path
  typedef enum logic [2:0] {
    PRSC_RUN   = 3'b000,
    PRSC_SLEEP = 3'b001,
    PRSC_START = 3'b011,
    PRSC_HALT  = 3'b010
  } prsc_state_t;

  // wake sources seen by the sleep controller
  typedef struct packed {
    logic [3:0]  irq_lo;    // ext_irq_lower_lines, any kind
    logic [3:0]  lvl_hi;    // ext_irq_upper_lines at active level
    logic        pin_chg;   // pin_change_irqs combined
    logic        watchdog_irq; // watchdog_timer interrupt
    logic        usb_wake;  // usb_bus_wake_irq
    logic        usb_sync;  // usb_frame_start_irq and other sync usb
    logic        cmp_irq;   // comparator interrupt
    logic        other_io;  // timers, serial, memory ready
  } prsc_wake_t;

  // clock gate enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic osc;
  } prsc_clk_t;

  typedef struct packed {
    logic [2:0]       mdiv;
    logic             mult_en;
    logic             locked;
    logic [19:0]      lock_cnt;
    logic             reg_off;
    logic [2:0]       mode;
    logic             slp_en;
    logic             cmp_dis;
    logic             xtal;
    prsc_state_t      st;
    logic [15:0]      wcnt;
    prsc_clk_t        clk;
    logic             halt;
    logic             irq_go;
    logic [2:0]       ws0;
    logic [2:0]       ws1;
    logic [2:0]       ws2;
    logic             msys;
    logic             mult_on;
    logic             rc_on;
    logic             d_ph;
    logic             d_wr;
    logic [7:0]       d_adr;
    logic [31:0]      rdata;
  } prsc_state_s_t;
endpackage

// ==== rtl/prsc_top.sv ====
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "prsc_defs.svh"
// How it works
// - multiplier register bits 7..5 read zero, reserved.
// - input divider code 000 divides by 1, 001 by 2; others reserved.
// - enable bit starts the multiplier and its rc reference if needed.
// - enable reads one while multiplier is system clock source.
// - lock flag in bit 0 set once multiplier has locked.
// - lock flag sets about 1 ms after enable, never beyond 100 ms.
// - regulator off bit switches regulator off; clears on every reset.
// - sleep happens only if enable bit set at sleep instruction, mode from field.
// - interrupt wake halts cpu four cycles past start-up, then runs handler.
// - state kept across sleep; reset during sleep wakes to reset vector.
// - mode field bits 3-1 decode five modes; bits 7-4 read zero.
// - idle stops only cpu and flash clocks.
// - idle wakes on any enabled interrupt; comparator disable removes comparator wake.
// - power-down stops oscillator; wakes only from listed asynchronous sources.
// - power-down wake waits the fuse-selected start-up delay.
// - power-save behaves exactly like power-down.
// - standby with crystal keeps oscillator, wakes in six cycles.
// - extended standby with crystal same as standby, six cycle wake.
// - outside idle only usb bus wake wakes among usb sources.
module prsc_top
  import prsc_pkg::*;
#(
  parameter int unsigned LOCK_CYC = `PRSC_LOCK_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sleep_instr,
  input  wire prsc_wake_t  wake_in,
  input  wire logic [15:0] startup_cyc,
  output logic             cpu_halt,
  output logic             irq_dispatch,
  output var prsc_clk_t    clk_en,
  output logic             mult_run,
  output logic             rc_ref_run,
  output logic [2:0]       mult_input_div,
  output logic             regulator_off
);
  // ****************************************
  // state
  // ****************************************
  prsc_state_s_t s_r;
  prsc_state_s_t s_nxt;
  logic [15:0]   wake_cyc;
  logic          wake_any;
  logic          go_sleep;
  logic [7:0]    wr_byte;

  // legal sleep request with mode check
  function automatic logic mode_ok(input logic [2:0] m, input logic x);
    unique case (m)
      `PRSC_MODE_IDLE, `PRSC_MODE_PDOWN, `PRSC_MODE_PSAVE: mode_ok = 1'b1;
      `PRSC_MODE_STBY, `PRSC_MODE_XSTBY: mode_ok = x;
      default: mode_ok = 1'b0;
    endcase
  endfunction

  // clock gates for a mode
  function automatic prsc_clk_t mode_clk(input logic [2:0] m);
    mode_clk = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, osc: 1'b0};
    if (m == `PRSC_MODE_IDLE) begin
      mode_clk.io  = 1'b1;
      mode_clk.osc = 1'b1;
    end else if (m == `PRSC_MODE_STBY || m == `PRSC_MODE_XSTBY) begin
      mode_clk.osc = 1'b1;
    end
  endfunction

  // ****************************************
  // combinational next state
  // ****************************************
  always_comb begin
    logic [2:0] lvl_q;
    lvl_q    = 3'h0;
    s_nxt    = s_r;
    wr_byte  = hwdata[7:0];
    go_sleep = sleep_instr && s_r.slp_en && mode_ok(s_r.mode, s_r.xtal);
    // pin sync: three flops, wake counted once stages two and three are both high
    s_nxt.ws0 = {wake_in.lvl_hi[0] | wake_in.irq_lo[0] | wake_in.pin_chg,
                 wake_in.usb_wake, wake_in.watchdog_irq};
    s_nxt.ws1 = s_r.ws0;
    s_nxt.ws2 = s_r.ws1;
    lvl_q     = s_r.ws1 & s_r.ws2;
    // asynchronous sources for deep modes
    wake_any  = (|lvl_q) | (|wake_in.irq_lo) | (|wake_in.lvl_hi);
    if (s_r.mode == `PRSC_MODE_IDLE) begin
      wake_any = wake_any | wake_in.usb_sync | wake_in.other_io | wake_in.pin_chg
                 | (wake_in.cmp_irq & ~s_r.cmp_dis);
    end
    // start-up delay per mode
    if (s_r.mode == `PRSC_MODE_STBY || s_r.mode == `PRSC_MODE_XSTBY) begin
      wake_cyc = 16'(`PRSC_STBY_CYC);
    end else if (s_r.mode == `PRSC_MODE_IDLE) begin
      wake_cyc = 16'h0001;
    end else begin
      wake_cyc = (startup_cyc == 16'h0000) ? 16'h0001 : startup_cyc;
    end

    // multiplier lock timer
    s_nxt.msys = s_r.msys;
    if (!(s_r.mult_en || s_r.msys)) begin
      s_nxt.lock_cnt = '0;
      s_nxt.locked   = 1'b0;
    end else if (!s_r.locked) begin
      if (s_r.lock_cnt >= LOCK_CYC[19:0] - 20'h0_0001) begin
        s_nxt.locked = 1'b1;
      end else begin
        s_nxt.lock_cnt = s_r.lock_cnt + 20'h0_0001;
      end
    end

    // sleep sequencer
    s_nxt.irq_go = 1'b0;
    unique case (s_r.st)
      PRSC_RUN: begin
        s_nxt.clk  = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
        s_nxt.halt = 1'b0;
        if (go_sleep) begin
          s_nxt.st   = PRSC_SLEEP;
          s_nxt.clk  = mode_clk(s_r.mode);
          s_nxt.halt = 1'b1;
        end
      end
      PRSC_SLEEP: begin
        if (wake_any) begin
          s_nxt.st   = PRSC_START;
          s_nxt.wcnt = wake_cyc;
          s_nxt.clk.osc = 1'b1;
        end
      end
      PRSC_START: begin
        s_nxt.wcnt = s_r.wcnt - 16'h0001;
        if (s_r.wcnt == 16'h0001) begin
          s_nxt.st   = PRSC_HALT;
          s_nxt.wcnt = 16'(`PRSC_HALT_CYC);
          s_nxt.clk  = '{cpu: 1'b0, flash: 1'b1, io: 1'b1, osc: 1'b1};
        end
      end
      PRSC_HALT: begin
        s_nxt.wcnt = s_r.wcnt - 16'h0001;
        if (s_r.wcnt == 16'h0001) begin
          s_nxt.st     = PRSC_RUN;
          s_nxt.halt   = 1'b0;
          s_nxt.irq_go = 1'b1;
          s_nxt.clk    = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
        end
      end
      default: s_nxt.st = PRSC_RUN;
    endcase

    // bus address phase
    if (hready) begin
      s_nxt.d_ph  = hsel && htrans[1];
      s_nxt.d_wr  = hwrite;
      s_nxt.d_adr = haddr[7:0];
    end
    // bus data phase write
    if (s_r.d_ph && s_r.d_wr) begin
      unique case (s_r.d_adr)
        `PRSC_OFS_MULT: begin
          s_nxt.mdiv    = wr_byte[`PRSC_MULT_DIV_HI:`PRSC_MULT_DIV_LO];
          s_nxt.mult_en = wr_byte[`PRSC_MULT_EN];
        end
        `PRSC_OFS_REG:   s_nxt.reg_off = wr_byte[0];
        `PRSC_OFS_SLEEP: begin
          s_nxt.mode   = wr_byte[`PRSC_SLP_MODE_HI:`PRSC_SLP_MODE_LO];
          s_nxt.slp_en = wr_byte[`PRSC_SLP_EN];
        end
        `PRSC_OFS_CFG: begin
          s_nxt.cmp_dis = wr_byte[`PRSC_CFG_CMPDIS];
          s_nxt.xtal    = wr_byte[`PRSC_CFG_XTAL];
          s_nxt.msys    = wr_byte[`PRSC_CFG_MSYS];
        end
        default: ;
      endcase
    end
    // read data for the next data phase
    s_nxt.rdata = `PRSC_RESET_DATA;
    if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `PRSC_OFS_MULT:  s_nxt.rdata = {24'h00_0000, 3'h0, s_r.mdiv,
                                        s_r.mult_en | s_r.msys, s_r.locked};
        `PRSC_OFS_REG:   s_nxt.rdata = {31'h0000_0000, s_r.reg_off};
        `PRSC_OFS_SLEEP: s_nxt.rdata = {24'h00_0000, 4'h0, s_r.mode, s_r.slp_en};
        `PRSC_OFS_CFG:   s_nxt.rdata = {29'h0000_0000, s_r.msys, s_r.xtal, s_r.cmp_dis};
        `PRSC_OFS_STAT:  s_nxt.rdata = {29'h0000_0000, s_r.st};
        default:         s_nxt.rdata = `PRSC_RESET_DATA;
      endcase
    end
    // run flags registered so the pins come from flops
    s_nxt.mult_on = s_nxt.mult_en | s_nxt.msys;
    s_nxt.rc_on   = (s_nxt.mult_en | s_nxt.msys) & ~s_nxt.xtal;
  end

  // ****************************************
  // state register, all control clears on reset except the clock enables, which reset to on
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r       <= '0;
      s_r.clk   <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops; hreadyout and hresp tied to constants
  assign hrdata         = s_r.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign cpu_halt       = s_r.halt;
  assign irq_dispatch   = s_r.irq_go;
  assign clk_en         = s_r.clk;
  assign mult_run       = s_r.mult_on;
  assign rc_ref_run     = s_r.rc_on;
  assign mult_input_div = s_r.mdiv;
  assign regulator_off  = s_r.reg_off;

  // ****************************************
  // checks
  // ****************************************
  sequence s_wake_done;
    cpu_halt [*4] ##1 (irq_dispatch && !cpu_halt);
  endsequence
  property p_halt4;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_r.st == PRSC_HALT) |-> s_wake_done;
  endproperty
  a_halt4: assert property (p_halt4) else $error("halt not four cycles");
  property p_nosleep;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_RUN && sleep_instr && !s_r.slp_en) |=> s_r.st == PRSC_RUN;
  endproperty
  a_nosleep: assert property (p_nosleep) else $error("slept without enable");
  property p_resv;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_RUN && !mode_ok(s_r.mode, s_r.xtal)) |=> s_r.st == PRSC_RUN;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved mode slept");
  property p_idle_clk;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && s_r.mode == `PRSC_MODE_IDLE) |-> clk_en.io && !clk_en.cpu;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clocks wrong");
  property p_pd_osc;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && s_r.mode[2:1] == 2'b01) |-> !clk_en.osc && !clk_en.io;
  endproperty
  a_pd_osc: assert property (p_pd_osc) else $error("powerdown clock on");
  property p_stby6;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && s_r.mode[2:1] == 2'b11 && wake_any) |=> ##6 s_r.st == PRSC_HALT;
  endproperty
  a_stby6: assert property (p_stby6) else $error("standby wake not six");
  property p_usb_deep;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && s_r.mode != `PRSC_MODE_IDLE && $stable(s_r.ws2) && !(|s_r.ws2)
       && !(|wake_in.irq_lo) && !(|wake_in.lvl_hi)) |=> s_r.st == PRSC_SLEEP;
  endproperty
  a_usb_deep: assert property (p_usb_deep) else $error("sync usb woke deep");
  property p_en_read;
    @(posedge hclk) disable iff (!hresetn)
      s_r.msys |-> mult_run;
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable not forced");
  property p_lock;
    @(posedge hclk) disable iff (!hresetn)
      $rose(s_r.locked) |-> $past(s_r.lock_cnt) == LOCK_CYC[19:0] - 20'h0_0001;
  endproperty
  a_lock: assert property (p_lock) else $error("lock time wrong");
  // ****************************************
  // register and wake checks
  // ****************************************
  // multiplier register reads zero above the divider field
  property p_mult_zero;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.d_ph && !s_r.d_wr && s_r.d_adr == `PRSC_OFS_MULT) |-> hrdata[31:5] == 27'h000_0000;
  endproperty
  a_mult_zero: assert property (p_mult_zero) else $error("multiplier upper bits set");
  // enable reads one while the multiplier drives the system clock
  property p_en_forced;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.d_ph && !s_r.d_wr && s_r.d_adr == `PRSC_OFS_MULT && $past(s_r.msys))
      |-> hrdata[`PRSC_MULT_EN];
  endproperty
  a_en_forced: assert property (p_en_forced) else $error("enable read not one");
  // divider pins follow the written field
  property p_div_wr;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.d_ph && s_r.d_wr && s_r.d_adr == `PRSC_OFS_MULT)
      |=> mult_input_div == $past(wr_byte[`PRSC_MULT_DIV_HI:`PRSC_MULT_DIV_LO]);
  endproperty
  a_div_wr: assert property (p_div_wr) else $error("divider not stored");
  // sleep register reads zero above the mode field
  property p_slp_zero;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.d_ph && !s_r.d_wr && s_r.d_adr == `PRSC_OFS_SLEEP) |-> hrdata[31:4] == 28'h000_0000;
  endproperty
  a_slp_zero: assert property (p_slp_zero) else $error("sleep upper bits set");
  // regulator pin follows the written bit
  property p_reg_wr;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.d_ph && s_r.d_wr && s_r.d_adr == `PRSC_OFS_REG)
      |=> regulator_off == $past(wr_byte[0]);
  endproperty
  a_reg_wr: assert property (p_reg_wr) else $error("regulator bit not stored");
  // a legal sleep request halts the cpu next cycle
  property p_sleep_go;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_RUN && go_sleep) |=> s_r.st == PRSC_SLEEP && cpu_halt;
  endproperty
  a_sleep_go: assert property (p_sleep_go) else $error("sleep not entered");
  // cpu stays halted while the clock restarts
  property p_start_halt;
    @(posedge hclk) disable iff (!hresetn)
      s_r.st == PRSC_START |-> cpu_halt && !clk_en.cpu && clk_en.osc;
  endproperty
  a_start_halt: assert property (p_start_halt) else $error("cpu ran during start-up");
  // idle wakes on a peripheral interrupt
  property p_idle_irq;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && s_r.mode == `PRSC_MODE_IDLE && wake_in.other_io)
      |=> s_r.st == PRSC_START;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("idle missed interrupt");
  // disabled comparator alone never wakes idle
  property p_cmp_off;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && s_r.mode == `PRSC_MODE_IDLE && s_r.cmp_dis && wake_in.cmp_irq
       && !wake_in.usb_sync && !wake_in.other_io && !wake_in.pin_chg
       && !(|wake_in.irq_lo) && !(|wake_in.lvl_hi) && !(|(s_r.ws1 & s_r.ws2)))
      |=> s_r.st == PRSC_SLEEP;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("disabled comparator woke");
  // lower interrupt lines wake every mode
  property p_low_wake;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && (|wake_in.irq_lo)) |=> s_r.st == PRSC_START;
  endproperty
  a_low_wake: assert property (p_low_wake) else $error("lower line missed");
  // standby keeps only the oscillator
  property p_stby_clk;
    @(posedge hclk) disable iff (!hresetn)
      (s_r.st == PRSC_SLEEP && s_r.mode[2:1] == 2'b11)
      |-> clk_en.osc && !clk_en.io && !clk_en.cpu;
  endproperty
  a_stby_clk: assert property (p_stby_clk) else $error("standby clocks wrong");
  // power-down start-up loads the fuse delay
  property p_fuse;
    @(posedge hclk) disable iff (!hresetn)
      ($rose(s_r.st == PRSC_START) && s_r.mode[2:1] == 2'b01 && $past(startup_cyc) != 16'h0000)
      |-> s_r.wcnt == $past(startup_cyc);
  endproperty
  a_fuse: assert property (p_fuse) else $error("start-up delay wrong");
  // rc reference only with multiplier running and no crystal
  property p_run_pins;
    @(posedge hclk) disable iff (!hresetn)
      rc_ref_run |-> mult_run && !s_r.xtal;
  endproperty
  a_run_pins: assert property (p_run_pins) else $error("rc reference wrong");
endmodule // prsc_top
`default_nettype wire

// ==== testbench/prsc_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// cpu core and wake source model
// ****************************************
module prsc_cpu_model
  import prsc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       go_sleep,
  input  wire prsc_wake_t wake_req,
  input  wire logic       drop,
  input  wire logic       irq_dispatch,
  output logic            sleep_instr,
  output var prsc_wake_t  wake_in
);
  // one sleep pulse per request; wake levels held until the handler runs or drop clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_instr <= 1'b0;
      wake_in     <= '0;
    end else begin
      sleep_instr <= go_sleep;
      wake_in     <= (irq_dispatch || drop) ? '0 : (wake_in | wake_req);
    end
  end
endmodule // prsc_cpu_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import prsc_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic        hclk, hresetn, hsel, hwrite, hready_o, hresp, go, drop, rd_ph, sleep_instr;
  logic [31:0] haddr, hwdata, hrdata, exp_rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, mdiv;
  logic [15:0] scyc;
  logic        cpu_halt, irq_dispatch, mult_run, rc_ref_run, regulator_off;
  prsc_clk_t   clk_en;
  prsc_wake_t  wreq, wake_in;
  logic [31:0] expq[$];
  int          bad_count, checks_done, cyc, n, base, m, b;
  logic [2:0]  md[5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [2:0]  rv[5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [3:0]  ce[5] = '{4'h3, 4'h0, 4'h0, 4'h1, 4'h1};
  int          dl[5];
  prsc_top #(.LOCK_CYC(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_o),
    .hrdata(hrdata), .hreadyout(hready_o), .hresp(hresp), .sleep_instr(sleep_instr),
    .wake_in(wake_in), .startup_cyc(scyc), .cpu_halt(cpu_halt), .irq_dispatch(irq_dispatch),
    .clk_en(clk_en), .mult_run(mult_run), .rc_ref_run(rc_ref_run), .mult_input_div(mdiv),
    .regulator_off(regulator_off));
  prsc_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .go_sleep(go), .wake_req(wreq),
    .drop(drop), .irq_dispatch(irq_dispatch), .sleep_instr(sleep_instr), .wake_in(wake_in));
  // ****************************************
  // clock, timeout, read monitor
  // ****************************************
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
    if (rd_ph && hready_o) begin
      exp_rd = expq.pop_front();
      `CHK({hresp, hrdata}, {1'b0, exp_rd})
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (!hready_o) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; rd_ph <= !w;
    @(posedge hclk);
    while (!hready_o) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    ahb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  // mode written with random reserved bits, then the sleep instruction
  task automatic slp(input logic [2:0] mo, input logic en, input logic h);
    logic [31:0] v;
    v = ($urandom & 32'h0000_00F0) | {28'h000_0000, mo, en};
    wr(8'h08, v);
    rd(8'h08, {28'h000_0000, mo, en});
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK(cpu_halt, h)
  endtask
  task automatic wk(input prsc_wake_t w, output int k);
    wreq <= w;
    @(posedge hclk);
    wreq <= '0;
    k = 0;
    while (irq_dispatch !== 1'b1 && k < 40) begin
      @(posedge hclk);
      k++;
    end
  endtask
  task automatic unstick();
    drop <= 1'b1;
    @(posedge hclk);
    drop <= 1'b0;
    wk(prsc_wake_t'(14'h0008), n);
  endtask
  task automatic stop_test();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; go = 0; drop = 0; rd_ph = 0; wreq = '0;
    void'($urandom(16));
    scyc = 16'h0002 + 16'($urandom % 16);
    dl = '{0, int'(scyc) - 1, int'(scyc) - 1, 5, 5};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(8'h00, 32'h0000_00E6);
    rd(8'h00, 32'h0000_0006);
    `CHK(mdiv, 3'h1)
    `CHK({mult_run, rc_ref_run}, 2'h3)
    repeat (30) @(posedge hclk);
    rd(8'h00, 32'h0000_0007);
    wr(8'h0C, 32'h0000_0004);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0002);
    wr(8'h00, 32'h0000_0002);
    @(posedge hclk);
    `CHK({mult_run, rc_ref_run}, 2'h2)
    `CHK(mdiv, 3'h0)
    wr(8'h00, 32'h0000_0000);
    for (m = 0; m < 5; m++) begin
      for (b = 0; b < 14; b++) begin
        slp(md[m], 1'b1, 1'b1);
        `CHK(clk_en, ce[m])
        wk(prsc_wake_t'(14'h0001 << b), n);
        `CHK(n < 40, m == 0 || b >= 3)
        if (n >= 40) unstick();
        if (b == 3 && m == 0) base = n;
        if (b == 3) `CHK(n - base, dl[m])
        @(posedge hclk);
        `CHK(clk_en, 4'hF)
        wr(8'h08, {28'h000_0000, md[m], 1'b0});
      end
    end
    wr(8'h0C, 32'h0000_0003);
    slp(3'h0, 1'b1, 1'b1);
    wk(prsc_wake_t'(14'h0002), n);
    `CHK(n < 40, 1'b0)
    unstick();
    wr(8'h0C, 32'h0000_0000);
    for (m = 0; m < 5; m++) slp(rv[m], 1'b1, 1'b0);
    slp(3'h0, 1'b0, 1'b0);
    wr(8'h04, 32'h0000_0001);
    @(posedge hclk);
    `CHK(regulator_off, 1'b1)
    rd(8'h04, 32'h0000_0001);
    slp(3'h2, 1'b1, 1'b1);
    rst();
    `CHK({cpu_halt, clk_en}, 5'h0F)
    `CHK(regulator_off, 1'b0)
    rd(8'h04, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    @(posedge hclk);
    `CHK(regulator_off, 1'b1)
    repeat (2) @(posedge hclk);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
